// file: design/ledmr_core.v
`timescale 1ns/1ps
`include "ledmr_regs.vh"

// Notes on behaviour
// R1: Master gives ninth clock for acknowledge
// R2: Receiver holds SDA low through acknowledge
// R3: Transmitter releases SDA during acknowledge
// R4: Master ends read by not acknowledging
// R5: Seven-bit slave address follows start
// R6: Two select pins pick one of four addresses
// R7: Eighth bit selects read or write
// R8: Acknowledge only own address, else stay off
// R9: Write: pointer byte then data, each acknowledged
// R10: Pointer advances after each written byte
// R11: Read needs pointer write then repeated start
// R12: Pointer advances on each master acknowledge; code advances it after every sent byte, nacked too
// R13: Read ends on no-acknowledge, SDA released
// R14: Repeated start begins a new address phase
// R15: Mode register holds three two-bit fields
// R16: Disabled, load, direct reset program counter
// R17: Disabled channel drives zero current
// R18: Host spaces mode writes over 153 us
// R19: Sixteen 16-bit instructions per channel
// R20: Storage at 10h-2Fh, 30h-4Fh, 50h-6Fh
// R21: Storage open only with a loading channel
// R22: Loading holds execution and freezes duty
// R23: Bytes are eight bits, MSB first
// R24: Start and stop detected at any time
// R25: Stray SDA change under high SCL aborts
// R26: Writes to non-loading storage are dropped
module ledmr_core #(
    parameter PROG_WORDS = 16
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Serial bus
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    // Address select straps
    input wire [1:0] addr_sel,
    // Channel control
    output reg [`LEDMR_MODE_W-1:0] channel_operation_mode,
    output reg [2:0] pc_clear,
    output reg [2:0] channel_off,
    output reg exec_hold,
    output reg [2:0] duty_freeze
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_PTR = 3'h2;
    localparam ST_WDATA = 3'h3;
    localparam ST_RDATA = 3'h4;
    localparam ST_IGNORE = 3'h5;

    wire scl;
    wire sda;
    reg scl_d;
    reg sda_d;
    reg [2:0] state;
    reg [2:0] bit_cnt;
    reg [7:0] shifter;
    reg [7:0] pointer;
    reg in_ack;
    reg ack_drive;
    reg rw_read;
    reg [7:0] tx_byte;
    reg master_nack;
    reg [7:0] mem [0:3*2*PROG_WORDS-1];
    reg [7:0] rd_data;
    reg first_fall;
    wire [1:0] sel;

    // --------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------
    // Straps are pins too; filtered like the bus lines
    ledmr_sync #(.RESET_VAL(1'b0)) u_sel0 (
        .clk_sys(clk_sys),
        .rst(rst),
        .line_in(addr_sel[0]),
        .line_out(sel[0])
    );
    ledmr_sync #(.RESET_VAL(1'b0)) u_sel1 (
        .clk_sys(clk_sys),
        .rst(rst),
        .line_in(addr_sel[1]),
        .line_out(sel[1])
    );
    ledmr_sync #(.RESET_VAL(1'b1)) u_scl (
        .clk_sys(clk_sys),
        .rst(rst),
        .line_in(scl_in),
        .line_out(scl)
    );
    ledmr_sync #(.RESET_VAL(1'b1)) u_sda (
        .clk_sys(clk_sys),
        .rst(rst),
        .line_in(sda_in),
        .line_out(sda)
    );

    // --------------------------------------------------------
    // Bus events
    // --------------------------------------------------------
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire start_ev = scl & scl_d & sda_d & ~sda; // [R24]
    wire stop_ev = scl & scl_d & ~sda_d & sda; // [R24]
    wire [6:0] own_addr = `LEDMR_ADDR_BASE + {5'h00, sel}; // [R6]

    // --------------------------------------------------------
    // Program storage decode
    // --------------------------------------------------------
    wire [7:0] prog_off = pointer - `LEDMR_PROG_LO;
    wire in_prog = (pointer >= `LEDMR_PROG_LO) &&
        (pointer <= `LEDMR_PROG_HI); // [R20]
    wire [1:0] prog_ch = (prog_off < `LEDMR_PROG_CH_BYTES) ? 2'h0 :
        (prog_off < (`LEDMR_PROG_CH_BYTES << 1)) ? 2'h1 : 2'h2;
    wire [1:0] mode_of_ch = (prog_ch == 2'h0) ?
        channel_operation_mode[`LEDMR_CH0_LSB+:2] :
        (prog_ch == 2'h1) ? channel_operation_mode[`LEDMR_CH1_LSB+:2] :
        channel_operation_mode[`LEDMR_CH2_LSB+:2];
    wire [2:0] loading;
    assign loading[0] =
        channel_operation_mode[`LEDMR_CH0_LSB+:2] == `LEDMR_MODE_LOAD;
    assign loading[1] =
        channel_operation_mode[`LEDMR_CH1_LSB+:2] == `LEDMR_MODE_LOAD;
    assign loading[2] =
        channel_operation_mode[`LEDMR_CH2_LSB+:2] == `LEDMR_MODE_LOAD;
    wire any_load = |loading;
    // Two bytes per instruction, channel by channel
    wire [6:0] mem_idx = prog_off[6:0];

    // --------------------------------------------------------
    // Read data select
    // --------------------------------------------------------
    // Unmapped addresses and closed storage read zero
    always @* begin
        rd_data = 8'h00;
        if (pointer == `LEDMR_REG_MODE) begin
            rd_data = {2'h0, channel_operation_mode};
        end else if (in_prog && any_load) begin // [R21]
            rd_data = mem[mem_idx];
        end
    end

    // --------------------------------------------------------
    // Bus state machine
    // --------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            state <= ST_IDLE;
            bit_cnt <= 3'h0;
            shifter <= 8'h00;
            pointer <= 8'h00;
            in_ack <= 1'b0;
            ack_drive <= 1'b0;
            rw_read <= 1'b0;
            tx_byte <= 8'h00;
            master_nack <= 1'b0;
            first_fall <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            channel_operation_mode <= `LEDMR_MODE_RESET;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
            if (start_ev) begin
                // Repeated start also lands here
                state <= ST_ADDR; // [R14]
                first_fall <= 1'b1;
                bit_cnt <= 3'h0;
                in_ack <= 1'b0;
                ack_drive <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop_ev) begin
                state <= ST_IDLE; // [R13]
                sda_oe <= 1'b0;
                in_ack <= 1'b0;
            end else if (scl && scl_d && (sda != sda_d) &&
                    state != ST_IDLE) begin
                // Cut transfer: stay off the bus until the next start
                state <= ST_IGNORE; // [R25]
                sda_oe <= 1'b0;
            end else if (scl_rise && state != ST_IDLE &&
                    state != ST_IGNORE) begin
                if (in_ack) begin
                    // Sample master acknowledge on read data
                    master_nack <= sda; // [R4]
                end else if (state != ST_RDATA) begin
                    shifter <= {shifter[6:0], sda}; // [R23]
                end
            end else if (scl_fall && state != ST_IDLE &&
                    state != ST_IGNORE) begin
                if (first_fall) begin
                    // Fall that closes the start is not a data bit
                    first_fall <= 1'b0;
                end else if (in_ack) begin
                    in_ack <= 1'b0;
                    sda_oe <= 1'b0;
                    bit_cnt <= 3'h0;
                    if (state == ST_ADDR) begin
                        if (!ack_drive) begin
                            state <= ST_IGNORE; // [R8]
                        end else if (rw_read) begin
                            state <= ST_RDATA;
                            tx_byte <= rd_data;
                            sda_out <= rd_data[7];
                            sda_oe <= ~rd_data[7];
                        end else begin
                            state <= ST_PTR; // [R9]
                        end
                    end else if (state == ST_PTR) begin
                        state <= ST_WDATA;
                    end else if (state == ST_RDATA) begin
                        if (master_nack) begin
                            state <= ST_IGNORE; // [R13]
                        end else begin
                            tx_byte <= rd_data; // [R12]
                            sda_out <= rd_data[7];
                            sda_oe <= ~rd_data[7];
                        end
                    end
                    ack_drive <= 1'b0;
                end else if (bit_cnt == `LEDMR_BIT_LAST) begin
                    in_ack <= 1'b1;
                    if (state == ST_ADDR) begin
                        rw_read <= shifter[0]; // [R7]
                        if (shifter[7:1] == own_addr) begin // [R5]
                            ack_drive <= 1'b1;
                            sda_out <= 1'b0;
                            sda_oe <= 1'b1; // [R2]
                        end
                    end else if (state == ST_PTR) begin
                        pointer <= shifter; // [R9]
                        sda_out <= 1'b0;
                        sda_oe <= 1'b1; // [R2]
                    end else if (state == ST_WDATA) begin
                        if (pointer == `LEDMR_REG_MODE) begin
                            channel_operation_mode <=
                                shifter[`LEDMR_MODE_W-1:0]; // [R15]
                        end
                        pointer <= pointer + 8'h01; // [R10]
                        sda_out <= 1'b0;
                        sda_oe <= 1'b1; // [R2]
                    end else begin
                        // Release for master acknowledge
                        sda_oe <= 1'b0; // [R3]
                        // Moves before the answer; a nack leaves it one past
                        pointer <= pointer + 8'h01; // [R12]
                    end
                end else begin
                    bit_cnt <= bit_cnt + 3'h1;
                    if (state == ST_RDATA) begin
                        sda_out <= tx_byte[3'h6 - bit_cnt]; // [R23]
                        sda_oe <= ~tx_byte[3'h6 - bit_cnt];
                    end
                end
            end
        end
    end

    // --------------------------------------------------------
    // Program storage write
    // --------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!rst && scl_fall && !in_ack && state == ST_WDATA &&
                bit_cnt == `LEDMR_BIT_LAST && !start_ev && !stop_ev &&
                in_prog && mode_of_ch == `LEDMR_MODE_LOAD) begin // [R26]
            mem[mem_idx] <= shifter; // [R19] [R21]
        end
    end

    // --------------------------------------------------------
    // Channel control outputs
    // --------------------------------------------------------
    // Registered so that every output comes from a flop
    integer i;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pc_clear <= 3'h7;
            channel_off <= 3'h7;
            exec_hold <= 1'b0;
            duty_freeze <= 3'h0;
        end else begin
            for (i = 0; i < 3; i = i + 1) begin
                pc_clear[i] <= (channel_operation_mode[(2-i)*2+:2] !=
                    `LEDMR_MODE_RUN); // [R16]
                channel_off[i] <= (channel_operation_mode[(2-i)*2+:2] ==
                    `LEDMR_MODE_DIS); // [R17]
                duty_freeze[i] <= any_load &&
                    (channel_operation_mode[(2-i)*2+:2] !=
                    `LEDMR_MODE_LOAD); // [R22]
            end
            exec_hold <= any_load; // [R22]
        end
    end
endmodule

// file: design/ledmr_sync.v
`timescale 1ns/1ps
// ------------------------------------------------------------
// Three-stage synchroniser with agreement filter
// ------------------------------------------------------------
module ledmr_sync #(
    parameter RESET_VAL = 1'b1
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Line
    input wire line_in,
    output reg line_out
);
    reg s1;
    reg s2;
    reg s3;

    // Only s2 and s3 are looked at; s1 may be metastable
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1 <= RESET_VAL;
            s2 <= RESET_VAL;
            s3 <= RESET_VAL;
            line_out <= RESET_VAL;
        end else begin
            s1 <= line_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                line_out <= s3;
            end
        end
    end
endmodule

// file: dv/i2c_led_mode_register_access_test.sv
`timescale 1ns/1ps
`include "ledmr_regs.vh"
module i2c_led_mode_register_access_test;
    typedef struct packed {
        logic [1:0] sel;
        logic [5:0] mode;
        logic [2:0] pcc;
        logic [2:0] off;
        logic hold;
        logic [2:0] frz;
    } ledmr_row_t;
    reg clk_sys = 1'b0;
    reg rst = 1'b1;
    reg [1:0] addr_sel = 2'h0;
    wire scl_drv, sda_drv, sda_out, sda_oe, exec_hold;
    wire [5:0] mode;
    wire [2:0] pc_clear, channel_off, duty_freeze;
    // Pull-up: low whenever either side pulls
    wire sda_line = sda_drv & ~(sda_oe & ~sda_out);
    integer errors = 0;
    integer n_tests = 0;
    integer i;
    reg [7:0] rd_a, rd_b;
    reg ack;
    ledmr_row_t rows [0:3] = '{'{2'h0, 6'h06, 3'h3, 3'h1, 1'b1, 3'h5},
        '{2'h1, 6'h39, 3'h5, 3'h0, 1'b1, 3'h3},
        '{2'h2, 6'h23, 3'h6, 3'h2, 1'b0, 3'h0},
        '{2'h3, 6'h15, 3'h7, 3'h0, 1'b1, 3'h0}};
    ledmr_core i_dut (.clk_sys(clk_sys), .rst(rst), .scl_in(scl_drv),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_sel(addr_sel), .channel_operation_mode(mode),
        .pc_clear(pc_clear), .channel_off(channel_off),
        .exec_hold(exec_hold), .duty_freeze(duty_freeze));
    ledmr_host i_host (.clk_sys(clk_sys), .sda_line(sda_line),
        .scl_drv(scl_drv), .sda_drv(sda_drv));
    task check(input string name, input [7:0] seen, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("wrong value %0s expected %h seen %h",
                    name, exp, seen);
            end
        end
    endtask
    task tx(input [7:0] b);
        begin
            i_host.send(b, ack);
            check("ack", {7'h0, ack}, 8'h01);
        end
    endtask
    task head(input [7:0] p);
        begin
            i_host.start;
            tx({`LEDMR_ADDR_BASE + addr_sel, 1'b0});
            tx(p);
        end
    endtask
    task wr(input [7:0] p, input [7:0] a, input [7:0] b, input two);
        begin
            head(p);
            tx(a);
            if (two) tx(b);
            i_host.stop;
        end
    endtask
    task rd(input [7:0] p, input [7:0] ea, input [7:0] eb, input two);
        begin
            head(p);
            i_host.start;
            tx({`LEDMR_ADDR_BASE + addr_sel, 1'b1});
            i_host.recv(!two, rd_a);
            check("data0", rd_a, ea);
            if (two) begin
                i_host.recv(1'b1, rd_b);
                check("data1", rd_b, eb);
            end
            i_host.stop;
        end
    endtask
    task set_mode(input [5:0] m);
        begin
            wr(`LEDMR_REG_MODE, {2'h0, m}, 8'h00, 1'b0);
            i_host.wt(1600);
        end
    endtask
    task tally_and_finish;
        begin
            if (errors == 0 && n_tests > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        #6000000;
        errors = errors + 1;
        tally_and_finish;
    end
    initial begin
        repeat (5) @(negedge clk_sys);
        check("pcc_rst", {5'h0, pc_clear}, 8'h07);
        check("off_rst", {5'h0, channel_off}, 8'h07);
        rst = 1'b0;
        i_host.wt(10);
        for (i = 0; i < 4; i = i + 1) begin
            addr_sel = rows[i].sel;
            set_mode(rows[i].mode);
            rd(`LEDMR_REG_MODE, {2'h0, rows[i].mode}, 8'h00, 1'b0);
            check("pcc", {5'h0, pc_clear}, {5'h0, rows[i].pcc});
            check("off", {5'h0, channel_off}, {5'h0, rows[i].off});
            check("hold", {7'h0, exec_hold}, {7'h0, rows[i].hold});
            check("frz", {5'h0, duty_freeze}, {5'h0, rows[i].frz});
            i_host.start;
            i_host.send({`LEDMR_ADDR_BASE + (addr_sel ^ 2'h1), 1'b0}, ack);
            i_host.stop;
            check("nack", {7'h0, ack}, 8'h00);
        end
        // Burst across the first/second channel boundary
        wr(8'h2F, 8'h11, 8'h22, 1'b1);
        rd(8'h2F, 8'h11, 8'h22, 1'b1);
        set_mode(6'h04);
        wr(8'h2F, 8'h33, 8'h44, 1'b1);
        rd(8'h30, 8'h44, 8'h00, 1'b0);
        set_mode(6'h10);
        rd(8'h2F, 8'h11, 8'h00, 1'b0);
        set_mode(6'h00);
        rd(8'h10, 8'h00, 8'h00, 1'b0);
        tally_and_finish;
    end
endmodule

// file: dv/ledmr_core_properties.sv
`timescale 1ns/1ps
`include "ledmr_regs.vh"
module ledmr_core_properties (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Serial bus
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    input wire [1:0] addr_sel,
    // Channel control
    input wire [`LEDMR_MODE_W-1:0] channel_operation_mode,
    input wire [2:0] pc_clear,
    input wire [2:0] channel_off,
    input wire exec_hold,
    input wire [2:0] duty_freeze
);
    wire [5:0] m = channel_operation_mode;
    wire [2:0] run = {m[1:0] == `LEDMR_MODE_RUN,
        m[3:2] == `LEDMR_MODE_RUN, m[5:4] == `LEDMR_MODE_RUN};
    wire [2:0] dis = {m[1:0] == `LEDMR_MODE_DIS,
        m[3:2] == `LEDMR_MODE_DIS, m[5:4] == `LEDMR_MODE_DIS};
    wire [2:0] load = {m[1:0] == `LEDMR_MODE_LOAD,
        m[3:2] == `LEDMR_MODE_LOAD, m[5:4] == `LEDMR_MODE_LOAD};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_drive_low_only: assert property (sda_oe |-> !sda_out)
        else $error("sda driven high");
    a_pc_clear_map: assert property ($stable(m) [*3] |->
        pc_clear == ~run) else $error("pc_clear mismatch");
    a_off_map: assert property ($stable(m) [*3] |->
        channel_off == dis) else $error("channel_off mismatch");
    a_hold_map: assert property ($stable(m) [*3] |->
        exec_hold == |load) else $error("exec_hold mismatch");
    a_freeze_map: assert property ($stable(m) [*3] |->
        duty_freeze == (|load ? ~load : 3'h0))
        else $error("duty_freeze mismatch");
    a_steady_scl_high: assert property (scl_in && $past(scl_in) |->
        $stable(sda_oe)) else $error("sda moved under high scl");
    a_start_quiet: assert property ($fell(sda_in) && scl_in |->
        !sda_oe [*8]) else $error("drive during address");
    a_stop_release: assert property ($rose(sda_in) && scl_in |->
        ##8 !sda_oe [*8]) else $error("drive after stop");
    a_mode_scl_low: assert property ($changed(m) |-> !scl_in)
        else $error("mode changed under high scl");
endmodule
bind ledmr_core ledmr_core_properties i_props (.clk_sys, .rst, .scl_in,
    .sda_in, .sda_out, .sda_oe, .addr_sel, .channel_operation_mode,
    .pc_clear, .channel_off, .exec_hold, .duty_freeze);

// file: dv/ledmr_host.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bus master model, open drain, 800 ns bit
// ------------------------------------------------------------
module ledmr_host (
    // Clock
    input wire clk_sys,
    // Bus
    input wire sda_line,
    output reg scl_drv,
    output reg sda_drv
);
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    task wt(input integer n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Low 6, high 2: slave answers about 5 cycles after a fall
    task bit_clk(input v, output s);
        begin
            wt(3);
            sda_drv = v;
            wt(3);
            scl_drv = 1'b1;
            wt(2);
            s = sda_line;
            scl_drv = 1'b0;
        end
    endtask
    task start;
        begin
            wt(3);
            sda_drv = 1'b1;
            wt(3);
            scl_drv = 1'b1;
            wt(2);
            sda_drv = 1'b0;
            wt(3);
            scl_drv = 1'b0;
        end
    endtask
    task stop;
        begin
            wt(3);
            sda_drv = 1'b0;
            wt(3);
            scl_drv = 1'b1;
            wt(3);
            sda_drv = 1'b1;
            wt(3);
        end
    endtask
    task send(input [7:0] b, output ack);
        integer i;
        reg s;
        begin
            for (i = 7; i >= 0; i = i - 1) bit_clk(b[i], s);
            bit_clk(1'b1, s);
            ack = ~s;
        end
    endtask
    task recv(input nack, output [7:0] d);
        integer i;
        reg s;
        begin
            for (i = 7; i >= 0; i = i - 1) bit_clk(1'b1, d[i]);
            bit_clk(nack, s);
        end
    endtask
endmodule

// file: shared/ledmr_regs.vh
`ifndef LEDMR_REGS_VH
`define LEDMR_REGS_VH

// ------------------------------------------------------------
// Slave addresses (7-bit form)
// ------------------------------------------------------------
`define LEDMR_ADDR_BASE 7'h32

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define LEDMR_REG_MODE 8'h01
`define LEDMR_PROG_LO 8'h10
`define LEDMR_PROG_HI 8'h6F
`define LEDMR_PROG_CH_BYTES 8'h20

// ------------------------------------------------------------
// Mode field layout and codes
// ------------------------------------------------------------
`define LEDMR_MODE_W 6
`define LEDMR_MODE_RESET 6'h00
`define LEDMR_MODE_DIS 2'h0
`define LEDMR_MODE_LOAD 2'h1
`define LEDMR_MODE_RUN 2'h2
`define LEDMR_MODE_DIRECT 2'h3
`define LEDMR_CH0_LSB 4
`define LEDMR_CH1_LSB 2
`define LEDMR_CH2_LSB 0

// ------------------------------------------------------------
// Sequencer bits
// ------------------------------------------------------------
`define LEDMR_BIT_LAST 3'h7
`define LEDMR_PC_ZERO 4'h0

`endif
